// File: dv/test_ual_unary_alu.sv
// test_ual_unary_alu: directed op sequences with expected results
// assumes: ual_pkg and ual_mem_model compiled first
`timescale 1ns/1ns
`default_nettype none
module test_ual_unary_alu;
   import ual_pkg::*;
   logic core_clk = 0, rst_b = 0, clkEn = 1, opValid = 0, wakeEvent = 0, dogExpiry = 0, halfIn = 0;
   ual_op_t opCode = UAL_OP_NONE;
   logic [3:0] memAddr = 4'h0;
   logic [7:0] memRdData, workReg, memWrData;
   logic memWrEn, nil, carry, slpFlag, dogFlag, dogClear, clkGate, execHalt;
   int errCount = 0, checks = 0;
   logic [7:0] bv [6] = '{8'h45, 8'h0a, 8'h42, 8'ha0, 8'h12, 8'h9a};
   logic [7:0] be [6] = '{8'h45, 8'h10, 8'h48, 8'h00, 8'h72, 8'h00};
   logic bh [6] = '{0, 0, 1, 0, 0, 0};
   logic bc [6] = '{0, 0, 0, 1, 1, 1};
   ual_unary_alu dut (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn), .opValid(opValid),
      .opCode(opCode), .memRdData(memRdData), .wakeEvent(wakeEvent), .dogExpiry(dogExpiry),
      .halfOverflowIn(halfIn), .workReg(workReg), .memWrData(memWrData), .memWrEn(memWrEn),
      .resultNilFlag(nil), .fullOverflowFlag(carry), .sleepEnteredFlag(slpFlag),
      .dogExpiryFlag(dogFlag), .dogClear(dogClear), .sysClkGate(clkGate), .execHalt(execHalt));
   ual_mem_model mdl (.core_clk(core_clk), .memAddr(memAddr), .memWrEn(memWrEn),
      .memWrData(memWrData), .memRdData(memRdData));
   ////////////////////////////////////////////////////////////////////////////////
   // 10 MHz clock
   always #50 core_clk = ~core_clk;
   task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         errCount++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic chk1(input string nm, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         errCount++;
         $display("[ERR] %s exp %b got %b", nm, exp, got);
      end
   endtask
   // one-cycle op, then sample mid-cycle after the answer lands
   task automatic exec(input ual_op_t op, input logic [3:0] a, input logic h = 0);
      @(posedge core_clk);
      opValid <= 1'b1;
      opCode <= op;
      memAddr <= a;
      halfIn <= h;
      @(posedge core_clk);
      opValid <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks, errCount);
      if (errCount == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // watchdog: the tests need about 75 cycles, so this leaves ample room
   initial begin
      repeat (3000) @(posedge core_clk);
      errCount++;
      test_done();
   end
   // main sequence
   initial begin
      mdl.mem[0] = 8'hff;
      mdl.mem[3] = 8'h7f;
      mdl.mem[4] = 8'h01;
      mdl.mem[5] = 8'ha5;
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      exec(UAL_OP_INC_M, 4'h0);
      chk8("inc data", 8'h00, memWrData);
      chk1("inc wr", 1'b1, memWrEn);
      chk1("inc nil", 1'b1, nil);
      chk1("inc carry", 1'b0, carry);
      exec(UAL_OP_DEC_M, 4'h0);
      chk8("dec data", 8'hff, memWrData);
      chk1("dec nil", 1'b0, nil);
      exec(UAL_OP_INC_W, 4'h0);
      chk8("incw wrap", 8'h00, workReg);
      chk1("incw nil", 1'b1, nil);
      exec(UAL_OP_INC_W, 4'h3);
      chk8("incw work", 8'h80, workReg);
      chk1("incw wr", 1'b0, memWrEn);
      exec(UAL_OP_DEC_W, 4'h4);
      chk8("decw work", 8'h00, workReg);
      chk1("decw nil", 1'b1, nil);
      exec(UAL_OP_INV_W, 4'h5);
      chk8("inv work", 8'h5a, workReg);
      chk1("inv wr", 1'b0, memWrEn);
      chk1("inv nil", 1'b0, nil);
      $display("test inc_dec_inv done");
      // bcd table: workReg loaded by inverting memory byte 1
      for (int i = 0; i < 6; i++) begin
         mdl.mem[1] = ~bv[i];
         exec(UAL_OP_INV_W, 4'h1);
         exec(UAL_OP_BCD, 4'h2, bh[i]);
         chk8("bcd data", be[i], memWrData);
         chk1("bcd wr", 1'b1, memWrEn);
         chk1("bcd carry", bc[i], carry);
         chk1("bcd nil", 1'b0, nil);
      end
      $display("test bcd done");
      @(posedge core_clk) dogExpiry <= 1'b1;
      repeat (4) @(posedge core_clk);
      dogExpiry <= 1'b0;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk1("dog set", 1'b1, dogFlag);
      exec(UAL_OP_SLEEP, 4'h0);
      chk1("gate", 1'b1, clkGate);
      chk1("halt", 1'b1, execHalt);
      chk1("dog clr", 1'b1, dogClear);
      chk1("slp flag", 1'b1, slpFlag);
      chk1("dog flag", 1'b0, dogFlag);
      chk1("slp carry", 1'b1, carry);
      exec(UAL_OP_INC_M, 4'h0);
      chk1("slp wr", 1'b0, memWrEn);
      chk8("slp work", 8'h9a, workReg);
      @(posedge core_clk) wakeEvent <= 1'b1;
      repeat (4) @(posedge core_clk);
      wakeEvent <= 1'b0;
      @(negedge core_clk);
      chk1("wake gate", 1'b0, clkGate);
      exec(UAL_OP_INC_W, 4'h3);
      chk8("wake work", 8'h80, workReg);
      $display("test sleep done");
      // a low enable must drop the op, the next one runs normally
      @(posedge core_clk) clkEn <= 1'b0;
      exec(UAL_OP_INC_W, 4'h4);
      chk8("frozen work", 8'h80, workReg);
      chk1("frozen wr", 1'b0, memWrEn);
      @(posedge core_clk) clkEn <= 1'b1;
      exec(UAL_OP_INC_W, 4'h4);
      chk8("thawed work", 8'h02, workReg);
      $display("test clock enable done");
      test_done();
   end
endmodule
`default_nettype wire

// File: dv/ual_mem_model.sv
// ual_mem_model: data memory on the far side of the block
// assumes: bench holds memAddr from one op to the next
`timescale 1ns/1ns
`default_nettype none
module ual_mem_model (
   input wire logic core_clk,
   input wire logic [3:0] memAddr,
   input wire logic memWrEn,
   input wire logic [7:0] memWrData,
   output logic [7:0] memRdData
);
   logic [7:0] mem [16];
   // read is combinational, so the byte is ready with opValid
   assign memRdData = mem[memAddr];
   // write lands on the edge that ends the pulse
   always @(posedge core_clk) begin
      if (memWrEn) begin
         mem[memAddr] <= memWrData;
      end
   end
endmodule
`default_nettype wire

// File: logic/ual_pkg.sv
// ual_pkg: opcodes, run states and constants for the unary alu block
// assumes: shared by the single design file, no other dependencies
`default_nettype none
package ual_pkg;
   // operation codes presented by the sequencer
   typedef enum logic [2:0] {
      UAL_OP_NONE = 3'b000,
      UAL_OP_INV_W = 3'b001,
      UAL_OP_BCD = 3'b010,
      UAL_OP_DEC_M = 3'b011,
      UAL_OP_DEC_W = 3'b100,
      UAL_OP_INC_M = 3'b101,
      UAL_OP_INC_W = 3'b110,
      UAL_OP_SLEEP = 3'b111
   } ual_op_t;

   // run state of the core as seen by this block
   typedef enum logic [0:0] {
      UAL_ST_RUN = 1'b0,
      UAL_ST_SLEEP = 1'b1
   } ual_state_t;

   localparam int UAL_DW = 8;
   localparam logic [7:0] UAL_ZERO = 8'h00;
   localparam logic [7:0] UAL_ONE = 8'h01;
   localparam logic [3:0] UAL_NIB_MAX = 4'h9;
   localparam logic [7:0] UAL_FIX_LO = 8'h06;
   localparam logic [7:0] UAL_FIX_HI = 8'h60;
   localparam logic [7:0] UAL_WREG_RST = 8'h00;
   localparam logic UAL_FLAG_RST = 1'b0;
endpackage
`default_nettype wire

// File: logic/ual_unary_alu.sv
// ual_unary_alu: single-operand instruction execution (invert, bcd fix, inc, dec, sleep)
// assumes: sequencer gives one-cycle opValid with memory byte already read;
//          memory write port and watchdog live outside this block
`timescale 1ns/1ns
`default_nettype none
module ual_unary_alu (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic opValid,
   input wire ual_pkg::ual_op_t opCode,
   input wire logic [7:0] memRdData,
   input wire logic wakeEvent,
   input wire logic dogExpiry,
   input wire logic halfOverflowIn,
   output logic [7:0] workReg,
   output logic [7:0] memWrData,
   output logic memWrEn,
   output logic resultNilFlag,
   output logic fullOverflowFlag,
   output logic sleepEnteredFlag,
   output logic dogExpiryFlag,
   output logic dogClear,
   output logic sysClkGate,
   output logic execHalt
);
   import ual_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0] workReg_q, memWrData_q;
   logic memWrEn_q, nil_q, fullOv_q, sleepF_q, dogF_q, dogClr_q;
   ual_state_t state_q, state_d;
   logic wake2_q, dog2_q; // settled outputs of the two pin synchronisers

   ////////////////////////////////////////////////////////////////////////
   // operand arithmetic, 8-bit apart from the 9-bit bcd sum, so wrap falls out naturally
   wire logic take = opValid && clkEn && (state_q == UAL_ST_RUN);
   wire logic [7:0] incVal = memRdData + UAL_ONE;
   wire logic [7:0] decVal = memRdData - UAL_ONE;
   wire logic [7:0] invVal = ~memRdData;
   wire logic fixLo = (workReg_q[3:0] > UAL_NIB_MAX) || halfOverflowIn;
   wire logic fixHi = (workReg_q[7:4] > UAL_NIB_MAX) || fullOv_q;
   wire logic [7:0] fixAdd = (fixLo ? UAL_FIX_LO : UAL_ZERO) | (fixHi ? UAL_FIX_HI : UAL_ZERO);
   // ninth bit carries the decimal overflow for chained adds
   wire logic [8:0] bcdSum = {1'b0, workReg_q} + {1'b0, fixAdd};
   wire logic bcdCarry = bcdSum[8] | fixHi;

   // result mux, named per destination
   wire logic toWork = (opCode == UAL_OP_INV_W) || (opCode == UAL_OP_DEC_W)
                       || (opCode == UAL_OP_INC_W);
   wire logic toMem = (opCode == UAL_OP_BCD) || (opCode == UAL_OP_DEC_M)
                      || (opCode == UAL_OP_INC_M);
   wire logic nilOp = toWork || (opCode == UAL_OP_DEC_M) || (opCode == UAL_OP_INC_M);
   wire logic [7:0] resVal =
      (opCode == UAL_OP_INV_W) ? invVal :
      (opCode == UAL_OP_BCD) ? bcdSum[7:0] :
      ((opCode == UAL_OP_DEC_M) || (opCode == UAL_OP_DEC_W)) ? decVal :
      incVal;
   wire logic goSleep = take && (opCode == UAL_OP_SLEEP);

   ////////////////////////////////////////////////////////////////////////
   // sleep state machine: only the synchronised wake pin ends sleep, dog expiry does not
   always_comb begin
      case (state_q)
         UAL_ST_RUN: state_d = goSleep ? UAL_ST_SLEEP : UAL_ST_RUN;
         UAL_ST_SLEEP: state_d = wake2_q ? UAL_ST_RUN : UAL_ST_SLEEP;
         default: state_d = UAL_ST_RUN;
      endcase
   end

   // pin synchronisers; they freeze with clkEn like every other flop, so a wake
   // pin raised while the enable is low is seen only once the enable returns
   ual_sync2 #(.WIDTH(1)) wakeSync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .pinIn(wakeEvent),
      .syncOut(wake2_q)
   );
   ual_sync2 #(.WIDTH(1)) dogSync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .pinIn(dogExpiry),
      .syncOut(dog2_q)
   );

   // datapath registers; memory and work only change on a taken op
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         workReg_q <= UAL_WREG_RST;
         memWrData_q <= UAL_ZERO;
         memWrEn_q <= 1'b0;
         nil_q <= UAL_FLAG_RST;
         fullOv_q <= UAL_FLAG_RST;
         state_q <= UAL_ST_RUN;
      end else if (clkEn) begin
         state_q <= state_d;
         memWrEn_q <= take && toMem;
         if (take && toMem)
            memWrData_q <= resVal;
         if (take && toWork)
            workReg_q <= resVal;
         if (take && nilOp)
            nil_q <= (resVal == UAL_ZERO);
         if (take && (opCode == UAL_OP_BCD))
            fullOv_q <= bcdCarry;
      end
   end

   // power/watchdog flags; expiry set beats the sleep clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sleepF_q <= UAL_FLAG_RST;
         dogF_q <= UAL_FLAG_RST;
         dogClr_q <= 1'b0;
      end else if (clkEn) begin
         dogClr_q <= goSleep;
         if (goSleep)
            sleepF_q <= 1'b1;
         if (dog2_q)
            dogF_q <= 1'b1;
         else if (goSleep)
            dogF_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign workReg = workReg_q;
   assign memWrData = memWrData_q;
   assign memWrEn = memWrEn_q;
   assign resultNilFlag = nil_q;
   assign fullOverflowFlag = fullOv_q;
   assign sleepEnteredFlag = sleepF_q;
   assign dogExpiryFlag = dogF_q;
   assign dogClear = dogClr_q;
   assign sysClkGate = (state_q == UAL_ST_SLEEP);
   assign execHalt = (state_q == UAL_ST_SLEEP);

   ////////////////////////////////////////////////////////////////////////
   // checks
   // each op check looks one cycle past the taking edge; a frozen next cycle
   // skips it, since the flops still hold their old values then
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // invert lands in the working register and never touches memory
   inv_to_work_a: assert property (take && opCode == UAL_OP_INV_W ##1 clkEn |->
      workReg == ~$past(memRdData) && !memWrEn) else $error("invert result wrong");

   // low nibble above nine gets the six added, high nibble left alone
   bcd_low_a: assert property (take && opCode == UAL_OP_BCD && workReg_q == 8'h0A
      && !halfOverflowIn && !fullOv_q ##1 clkEn |-> memWrData == 8'h10)
      else $error("bcd low fix wrong");

   // no nibble test true means the byte passes through untouched
   bcd_plain_a: assert property (take && opCode == UAL_OP_BCD && !fixLo && !fixHi
      ##1 clkEn |-> memWrData == $past(workReg)) else $error("bcd plain pass wrong");

   // high nibble above nine wraps past the byte and raises the carry
   bcd_high_a: assert property (take && opCode == UAL_OP_BCD && workReg_q == 8'hA0
      && !halfOverflowIn ##1 clkEn |-> memWrData == 8'h00 && fullOverflowFlag)
      else $error("bcd high fix wrong");

   // both nibble tests together select the largest correction
   bcd_both_a: assert property (take && opCode == UAL_OP_BCD && fixLo && fixHi
      ##1 clkEn |-> memWrData == $past(workReg) + 8'h66)
      else $error("bcd double fix wrong");

   // adjusted sum goes to memory, the working register keeps its value
   bcd_store_a: assert property (take && opCode == UAL_OP_BCD ##1 clkEn |->
      memWrEn && workReg == $past(workReg)) else $error("bcd store wrong");

   // the zero flag is not one of the flags that decimal adjust may touch
   bcd_flags_a: assert property (take && opCode == UAL_OP_BCD ##1 clkEn |->
      $stable(resultNilFlag)) else $error("bcd touched zero flag");

   // a carry from the earlier add survives the adjust, so chains keep it
   bcd_hold_a: assert property (take && opCode == UAL_OP_BCD && fullOverflowFlag
      ##1 clkEn |-> fullOverflowFlag) else $error("bcd dropped carry");

   // decrement in place writes back through the memory port
   dec_mem_a: assert property (take && opCode == UAL_OP_DEC_M ##1 clkEn |->
      memWrEn && memWrData == $past(memRdData) - 8'h01) else $error("decrement wrong");

   // a memory write strobe with no new op behind it lasts one cycle
   mem_pulse_a: assert property (memWrEn && clkEn && !opValid |=> !memWrEn)
      else $error("memory write strobe too long");

   // decrement to work leaves the memory byte alone
   dec_work_a: assert property (take && opCode == UAL_OP_DEC_W ##1 clkEn |->
      !memWrEn && workReg == $past(memRdData) - 8'h01) else $error("decrement to work wrong");

   // sleep gates the clock and halts the sequencer, contents kept
   sleep_gate_a: assert property (goSleep ##1 clkEn |-> sysClkGate && execHalt
      && $stable(workReg)) else $error("sleep entry wrong");

   // requests that arrive while asleep are dropped without a trace
   sleep_drop_a: assert property (opValid && clkEn && state_q == UAL_ST_SLEEP
      ##1 clkEn |-> !memWrEn && $stable(workReg))
      else $error("op taken while asleep");

   // only a synchronised wake can end the sleep
   sleep_stay_a: assert property (state_q == UAL_ST_SLEEP && !wake2_q |=>
      sysClkGate && execHalt) else $error("left sleep without wake");

   // a settled wake releases the clock gate on the next edge
   wake_exit_a: assert property (state_q == UAL_ST_SLEEP && wake2_q && clkEn |=>
      !sysClkGate && !execHalt) else $error("wake did not end sleep");

   // a low enable holds every flop, so nothing visible may move
   freeze_hold_a: assert property (!clkEn |=> $stable(workReg) && $stable(memWrEn)
      && $stable(resultNilFlag) && $stable(sysClkGate))
      else $error("state moved while frozen");

   // sleep entry flags, unless an expiry lands in the same cycle
   sleep_flags_a: assert property (goSleep && !dog2_q ##1 clkEn |-> dogClear
      && sleepEnteredFlag && !dogExpiryFlag) else $error("sleep flags wrong");

   // sleep leaves the zero and carry flags as they were
   sleep_keep_a: assert property (goSleep ##1 clkEn |-> $stable(resultNilFlag)
      && $stable(fullOverflowFlag)) else $error("sleep changed other flags");

   // the watchdog clear is a single-cycle strobe
   dog_pulse_a: assert property (dogClear && clkEn |=> !dogClear)
      else $error("watchdog clear longer than one cycle");

   // increment in place writes back through the memory port
   inc_mem_a: assert property (take && opCode == UAL_OP_INC_M ##1 clkEn |->
      memWrEn && memWrData == $past(memRdData) + 8'h01) else $error("increment wrong");

   // increment to work leaves the memory byte alone
   inc_work_a: assert property (take && opCode == UAL_OP_INC_W ##1 clkEn |->
      !memWrEn && workReg == $past(memRdData) + 8'h01) else $error("increment to work wrong");

   // zero flag follows the 8-bit result of every op that updates it
   nil_set_a: assert property (take && nilOp ##1 clkEn |->
      resultNilFlag == ($past(resVal) == 8'h00)) else $error("zero flag wrong");

   // increment of all ones wraps to zero
   inc_wrap_a: assert property (take && opCode == UAL_OP_INC_W && memRdData == 8'hFF
      ##1 clkEn |-> workReg == 8'h00 && $stable(fullOverflowFlag))
      else $error("increment wrap wrong");

   // decrement of zero wraps to all ones
   dec_wrap_a: assert property (take && opCode == UAL_OP_DEC_M && memRdData == 8'h00
      ##1 clkEn |-> memWrData == 8'hFF && $stable(fullOverflowFlag))
      else $error("decrement wrap wrong");

   // steps of one never disturb the carry
   step_flags_a: assert property (take && nilOp && opCode != UAL_OP_INV_W ##1 clkEn
      |-> $stable(fullOverflowFlag)) else $error("step changed carry");

   // main scenarios: plain step, both bcd fixes, sleep round trip, freeze, wrap
   inc_c: cover property (take && opCode == UAL_OP_INC_M);
   bcd_c: cover property (take && opCode == UAL_OP_BCD && fixLo && fixHi);
   sleep_c: cover property (goSleep ##[1:20] state_q == UAL_ST_RUN);
   freeze_c: cover property (!clkEn && opValid);
   wrap_c: cover property (take && opCode == UAL_OP_DEC_M && memRdData == 8'h00);
endmodule

////////////////////////////////////////////////////////////////////////
// ual_sync2: two-flop synchroniser for a level pin, frozen with the clock enable
// only the second flop is visible, so nothing can read a half-settled value
module ual_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // one enable for every flop of the block keeps a frozen core coherent
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (clkEn) begin
         meta_q <= pinIn;
         sync_q <= meta_q;
      end
   end

   assign syncOut = sync_q;
endmodule
`default_nettype wire
